// *** tb_top.sv ***
// testbench for the link controller
// assumes one far node on the bus and full-length timing
`timescale 1ns/100ps
`include "vpw_link_regs.vh"
module tb_top;
reg mclk = 1'b0;
reg rst = 1'b1;
reg data_port_write = 1'b0;
reg [7:0] transmit_receive_data_port = 8'h00;
reg tx_last = 1'b0;
reg arm = 1'b0;
reg seen;
wire bus;
wire bus_drive;
wire [7:0] rx_byte;
wire arb_lost;
wire symbol_error;
wire bus_idle;
wire tx_busy;
integer bad_count = 0;
integer check_count = 0;
integer n;
always #4 mclk = ~mclk;
vpw_far_node u_node (.mclk(mclk), .arm(arm), .dev_drive(bus_drive), .bus(bus));
vpw_link_controller u_dut (.mclk(mclk), .rst(rst), .bus_receive_input(bus),
    .data_port_write(data_port_write), .transmit_receive_data_port(transmit_receive_data_port),
    .tx_last(tx_last), .bus_drive(bus_drive), .rx_byte(rx_byte), .rx_byte_stb(),
    .rx_symbol(), .rx_symbol_stb(), .symbol_error(symbol_error), .arb_lost(arb_lost),
    .tx_busy(tx_busy), .tx_byte_taken(), .bus_idle(bus_idle));
// ****************
// tasks
// ****************
task check(input string name, input [15:0] exp, input [15:0] got);
    begin
        check_count = check_count + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    end
endtask
task wrap_up;
    begin
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    end
endtask
task test_reset;
    begin
        @(negedge mclk);
        check("idle", 1, bus_idle);
        check("drive", 0, bus_drive);
        check("busy", 0, tx_busy);
    end
endtask
task test_start;
    begin
        @(posedge mclk);
        data_port_write <= 1'b1;
        transmit_receive_data_port <= 8'hC0;
        tx_last <= 1'b1;
        arm <= 1'b1;
        @(posedge mclk);
        data_port_write <= 1'b0;
        for (n = 0; n < 8 && bus_drive !== 1'b1; n = n + 1) @(negedge mclk);
        check("start", 1, bus_drive);
        for (n = 0; n < 30000 && bus_drive === 1'b1; n = n + 1) @(negedge mclk);
        check("sof len", 1, n >= 24999 && n <= 25001);
    end
endtask
task test_lose;
    begin
        for (n = 0; n < 17000 && arb_lost !== 1'b1; n = n + 1) @(negedge mclk);
        check("lost", 1, arb_lost);
        seen = 1'b0;
        for (n = 0; n < 70000 && u_dut.rx_byte_stb !== 1'b1; n = n + 1) begin
            @(negedge mclk);
            seen = seen | bus_drive;
        end
        check("released", 0, seen);
        check("rx byte", 8'h55, rx_byte);
        for (n = 0; n < 4000 && symbol_error !== 1'b1; n = n + 1) @(negedge mclk);
        check("symbol error", 1, symbol_error);
    end
endtask
// ****************
// main sequence
// ****************
initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    test_reset;
    test_start;
    test_lose;
    wrap_up;
end
initial begin
    repeat (110000) @(posedge mclk);
    bad_count = bad_count + 1;
    wrap_up;
end
endmodule

// *** vpw_far_node.sv ***
// far node: joins a frame on a seen rising edge and sends one byte
// assumes wired bus, active high, passive pulled low
`timescale 1ns/100ps
`include "vpw_link_regs.vh"
module vpw_far_node #(
    parameter [7:0] MSG = 8'h55,
    parameter SHORT = `T_SHORT_US * `CLK_MHZ,
    parameter LONG = `T_LONG_US * `CLK_MHZ,
    parameter SOF = `T_SOF_US * `CLK_MHZ,
    parameter GAP = 20 * `CLK_MHZ
) (
    input wire mclk,
    input wire arm,
    input wire dev_drive,
    output wire bus
);
reg node_drive;
reg last;
assign bus = dev_drive | node_drive;
// ****************
// frame sender
// ****************
task send_frame;
    integer i;
    reg lvl;
    begin
        node_drive <= 1'b1;
        repeat (SOF) @(posedge mclk);
        for (i = 7; i >= 0; i = i - 1) begin
            lvl = (i % 2 == 0);
            node_drive <= lvl;
            repeat ((MSG[i] == lvl) ? SHORT : LONG) @(posedge mclk);
        end
        node_drive <= 1'b0;
        repeat (GAP) @(posedge mclk);
        node_drive <= 1'b1;
        repeat (SHORT) @(posedge mclk);
        node_drive <= 1'b0;
    end
endtask
initial begin
    node_drive = 1'b0;
    last = 1'b0;
    forever begin
        @(posedge mclk);
        if (arm && bus && !last) begin
            send_frame;
        end
        last = bus;
    end
end
endmodule

// *** vpw_link_controller.v ***
// link_controller receive classifier, arbitration and shift paths
// assumes bus_receive_input synchronous to mclk, high = active bus level
`timescale 1ns/100ps
`include "vpw_link_regs.vh"

// Functional notes
// - time each received symbol in whole interface clock periods
// - classification windows touch: each upper limit equals next lower limit, except active fourth to break threshold
// - passive interval shorter than first threshold is an invalid bit
// - passive between first and second is 0, second and third is 1
// - passive between third and fourth thresholds is end of data
// - next rising edge inside end-of-frame window gives end of frame
// - next rising edge in later window gives end of frame plus separation
// - pending transmit after end of frame starts on any rising edge
// - no rising edge before final passive threshold means idle bus
// - active below first is invalid, then logic 1, then logic 0
// - active between third and fourth thresholds is start of frame
// - active beyond break threshold is a break symbol
// - transmit request during another message waits for end of frame or idle bus
// - arbitrate bit by bit from first bit after start of frame
// - write within 104 periods of rising edge joins that frame
// - later write waits for end of frame or idle bus
// - logic 0 dominant, logic 1 recessive
// - recessive sent but dominant seen: lose and release bus at once
// - any mismatch halts transmit except on last bit of byte
// - mismatch on last bit appends up to two logic 1 bits
// - second appended 1 dropped if first appended bit loses
// - received bits assemble in shift register, byte handed in parallel
// - transmit shift register loads in parallel, bits out serially
// - nominal bits 64 or 128 us by level and value
// - start of frame 200 us active, end of data 200 us passive
// - end of frame 280 us, separation to 300 us, longer is idle
// - break is active at least 240 us
module vpw_link_controller #(
    parameter JOIN = `JOIN_WIN,
    parameter SOF_CNT = `T_SOF_US * `CLK_MHZ,
    parameter SHORT_CNT = `T_SHORT_US * `CLK_MHZ,
    parameter LONG_CNT = `T_LONG_US * `CLK_MHZ
) (
    input wire mclk,
    input wire rst,
    input wire bus_receive_input,
    input wire data_port_write,
    input wire [7:0] transmit_receive_data_port,
    input wire tx_last,
    output reg bus_drive,
    output reg [7:0] rx_byte,
    output reg rx_byte_stb,
    output reg [3:0] rx_symbol,
    output reg rx_symbol_stb,
    output reg symbol_error,
    output reg arb_lost,
    output reg tx_busy,
    output reg tx_byte_taken,
    output reg bus_idle
);
    localparam S_IDLE = 6'b000001;
    localparam S_WAIT = 6'b000010;
    localparam S_SOF = 6'b000100;
    localparam S_BIT = 6'b001000;
    localparam S_PAD = 6'b010000;
    localparam S_EOD = 6'b100000;

    wire [3:0] sym;
    wire sym_stb;
    wire rise_stb;
    wire [`CNT_W-1:0] count;
    wire level;
    wire [7:0] rx_shift_data;
    wire [7:0] tx_shift_data;
    wire tx_msb;

    reg [5:0] state;
    reg [7:0] hold;
    reg hold_full;
    reg [2:0] rx_bits;
    reg [2:0] tx_bits;
    reg tx_load;
    reg tx_shift;
    reg rx_shift;
    reg rx_bit_val;
    reg cur_bit;
    reg [`CNT_W-1:0] drive_cnt;
    reg [1:0] pad_left;
    reg in_frame;
    reg eof_ok;
    reg ifs_done;
    reg join_ok;
    reg [7:0] join_cnt;
    reg more;

    vpw_symbol_classifier u_class (
        .mclk(mclk),
        .rst(rst),
        .rx(bus_receive_input),
        .sym(sym),
        .sym_stb(sym_stb),
        .rise_stb(rise_stb),
        .count(count),
        .level(level)
    );

    vpw_shift_byte #(.W(8)) u_rx_shift (
        .mclk(mclk),
        .rst(rst),
        .load(1'b0),
        .load_data(8'h00),
        .shift(rx_shift),
        .shift_in(rx_bit_val),
        .data(rx_shift_data),
        .msb()
    );

    vpw_shift_byte #(.W(8)) u_tx_shift (
        .mclk(mclk),
        .rst(rst),
        .load(tx_load),
        .load_data(hold),
        .shift(tx_shift),
        .shift_in(1'b1),
        .data(tx_shift_data),
        .msb(tx_msb)
    );

    // drive length of one symbol; level alternates so width encodes value
    function [`CNT_W-1:0] bit_len;
        input b;
        input lvl;
        begin
            if (b ^ lvl)
                bit_len = LONG_CNT[`CNT_W-1:0];
            else
                bit_len = SHORT_CNT[`CNT_W-1:0];
        end
    endfunction

    wire is_data;
    assign is_data = sym_stb && (sym == `SYM_BIT0 || sym == `SYM_BIT1);

    // ******************************************
    // receive path
    // ******************************************
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_bits <= 3'h0;
            rx_shift <= 1'b0;
            rx_bit_val <= 1'b0;
            rx_byte <= 8'h00;
            rx_byte_stb <= 1'b0;
            rx_symbol <= `SYM_NONE;
            rx_symbol_stb <= 1'b0;
            symbol_error <= 1'b0;
            in_frame <= 1'b0;
            eof_ok <= 1'b0;
            ifs_done <= 1'b1;
            bus_idle <= 1'b1;
            join_cnt <= 8'hFF;
        end else begin
            rx_shift <= 1'b0;
            rx_byte_stb <= 1'b0;
            rx_symbol_stb <= sym_stb;
            symbol_error <= 1'b0;
            if (sym_stb)
                rx_symbol <= sym;
            if (rise_stb)
                join_cnt <= 8'h00;
            else if (join_cnt != 8'hFF)
                join_cnt <= join_cnt + 8'h01;
            if (rx_shift) begin
                rx_bits <= rx_bits + 3'h1;
                if (rx_bits == 3'h7) begin
                    rx_byte <= {rx_shift_data[6:0], rx_bit_val};
                    rx_byte_stb <= 1'b1;
                end
            end
            if (rise_stb)
                bus_idle <= 1'b0;
            if (sym_stb) begin
                if (sym == `SYM_SOF) begin
                    in_frame <= 1'b1;
                    rx_bits <= 3'h0;
                    eof_ok <= 1'b0;
                    ifs_done <= 1'b0;
                    bus_idle <= 1'b0;
                end else if (is_data && in_frame) begin
                    rx_shift <= 1'b1;
                    rx_bit_val <= (sym == `SYM_BIT1);
                end else if (sym == `SYM_INV || sym == `SYM_BRK) begin
                    symbol_error <= in_frame || (sym == `SYM_BRK);
                    in_frame <= 1'b0;
                    bus_idle <= 1'b0;
                end else if (sym == `SYM_EOF) begin
                    eof_ok <= 1'b1;
                    in_frame <= 1'b0;
                end else if (sym == `SYM_IDLE) begin
                    ifs_done <= 1'b1;
                    bus_idle <= 1'b1;
                    eof_ok <= 1'b0;
                end
            end
        end
    end

    // ******************************************
    // transmit and arbitration
    // ******************************************
    wire mismatch;
    assign mismatch = is_data && ((sym == `SYM_BIT1) != cur_bit);

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            hold <= 8'h00;
            hold_full <= 1'b0;
            join_ok <= 1'b0;
            more <= 1'b0;
            tx_load <= 1'b0;
            tx_shift <= 1'b0;
            tx_bits <= 3'h0;
            cur_bit <= 1'b1;
            drive_cnt <= 16'h0000;
            pad_left <= 2'h0;
            bus_drive <= 1'b0;
            arb_lost <= 1'b0;
            tx_busy <= 1'b0;
            tx_byte_taken <= 1'b0;
        end else begin
            tx_load <= 1'b0;
            tx_shift <= 1'b0;
            arb_lost <= 1'b0;
            tx_byte_taken <= 1'b0;
            if (data_port_write && !hold_full) begin
                hold <= transmit_receive_data_port;
                hold_full <= 1'b1;
                more <= !tx_last;
                join_ok <= (join_cnt <= JOIN[7:0]) && !in_frame;
            end
            if (drive_cnt != 16'h0000)
                drive_cnt <= drive_cnt - 16'h0001;
            case (state)
                S_IDLE: begin
                    tx_busy <= hold_full;
                    if (hold_full)
                        state <= S_WAIT;
                end
                S_WAIT: begin
                    // start on idle bus, while the bus is active after a write within the join window, or on a rising edge after end of frame
                    if ((bus_idle && !level) || (join_ok && level) ||
                            (eof_ok && rise_stb)) begin
                        bus_drive <= 1'b1;
                        if (level)
                            drive_cnt <= SOF_CNT[`CNT_W-1:0] - count;
                        else
                            drive_cnt <= SOF_CNT[`CNT_W-1:0];
                        state <= S_SOF;
                        tx_load <= 1'b1;
                        hold_full <= 1'b0;
                        tx_byte_taken <= 1'b1;
                        tx_bits <= 3'h0;
                        join_ok <= 1'b0;
                    end
                end
                S_SOF: begin
                    if (drive_cnt == 16'h0001) begin
                        bus_drive <= 1'b0;
                        cur_bit <= tx_msb;
                        drive_cnt <= bit_len(tx_msb, 1'b0);
                        tx_shift <= 1'b1;
                        state <= S_BIT;
                    end
                end
                S_BIT, S_PAD: begin
                    if (mismatch && state == S_PAD) begin
                        bus_drive <= 1'b0;
                        arb_lost <= 1'b1;
                        state <= S_IDLE;
                    end else if (mismatch && tx_bits != 3'h7) begin
                        bus_drive <= 1'b0;
                        arb_lost <= 1'b1;
                        state <= S_IDLE;
                    end else if (sym_stb && sym == `SYM_BRK) begin
                        bus_drive <= 1'b0;
                        state <= S_IDLE;
                    end else if (is_data || drive_cnt == 16'h0001) begin
                        if (mismatch || state == S_PAD) begin
                            if (mismatch)
                                pad_left <= 2'h2;
                            if (mismatch || pad_left != 2'h0) begin
                                pad_left <= mismatch ? 2'h1 : pad_left - 2'h1;
                                cur_bit <= 1'b1;
                                bus_drive <= !bus_drive;
                                drive_cnt <= bit_len(1'b1, !bus_drive);
                                state <= S_PAD;
                            end else begin
                                bus_drive <= 1'b0;
                                state <= S_IDLE;
                            end
                        end else begin
                            tx_bits <= tx_bits + 3'h1;
                            if (tx_bits == 3'h7 && !(more && hold_full)) begin
                                bus_drive <= 1'b0;
                                drive_cnt <= SOF_CNT[`CNT_W-1:0];
                                state <= S_EOD;
                            end else begin
                                if (tx_bits == 3'h7) begin
                                    tx_load <= 1'b1;
                                    hold_full <= 1'b0;
                                    tx_byte_taken <= 1'b1;
                                end else
                                    tx_shift <= 1'b1;
                                cur_bit <= (tx_bits == 3'h7) ? hold[7] : tx_msb;
                                bus_drive <= !bus_drive;
                                drive_cnt <= bit_len((tx_bits == 3'h7) ? hold[7] : tx_msb,
                                    !bus_drive);
                            end
                        end
                    end
                end
                S_EOD: begin
                    if (drive_cnt == 16'h0001)
                        state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule

// *** vpw_link_controller_properties.sv ***
// checker for the link controller ports
// assumes bus_receive_input high = active, mclk at 125 MHz
`timescale 1ns/100ps
`include "vpw_link_regs.vh"
module vpw_link_checker #(
    parameter SOF_CNT = `T_SOF_US * `CLK_MHZ,
    parameter SHORT_CNT = `T_SHORT_US * `CLK_MHZ,
    parameter LONG_CNT = `T_LONG_US * `CLK_MHZ
) (
    input wire mclk,
    input wire rst,
    input wire bus_receive_input,
    input wire data_port_write,
    input wire bus_drive,
    input wire [3:0] rx_symbol,
    input wire rx_symbol_stb,
    input wire arb_lost,
    input wire tx_busy,
    input wire tx_byte_taken,
    input wire bus_idle
);
// ****************
// helper logic
// ****************
localparam integer M = 3;
localparam integer C = `CLK_MHZ;
reg last;
reg [15:0] run;
reg [15:0] drv;
reg [3:0] exp_q;
wire chg = bus_receive_input != last;
function in_band(input [15:0] n, input integer lo, input integer hi);
    in_band = (n > lo * C + M) && (n < hi * C - M);
endfunction
function [3:0] classify(input lvl, input [15:0] n);
    begin
        classify = `SYM_NONE;
        if (n < (lvl ? `A_A_US : `P_A_US) * C - M) classify = `SYM_INV;
        if (!lvl && in_band(n, `P_A_US, `P_B_US)) classify = `SYM_BIT0;
        if (!lvl && in_band(n, `P_B_US, `P_C_US)) classify = `SYM_BIT1;
        if (!lvl && in_band(n, `P_C_US, `P_D_US)) classify = `SYM_EOD;
        if (lvl && in_band(n, `A_A_US, `A_B_US)) classify = `SYM_BIT1;
        if (lvl && in_band(n, `A_B_US, `A_C_US)) classify = `SYM_BIT0;
        if (lvl && in_band(n, `A_C_US, `A_D_US)) classify = `SYM_SOF;
    end
endfunction
wire [3:0] pred = classify(last, run);
wire drv_ok = (drv + 16'h0001 >= SOF_CNT && drv <= SOF_CNT + 1)
    || (drv + 16'h0001 >= SHORT_CNT && drv <= SHORT_CNT + 1)
    || (drv + 16'h0001 >= LONG_CNT && drv <= LONG_CNT + 1);
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        last <= 1'b0;
        run <= 16'hFFFF;
        drv <= 16'h0000;
        exp_q <= `SYM_NONE;
    end else begin
        last <= bus_receive_input;
        if (chg) begin
            run <= 16'h0001;
            exp_q <= pred;
        end else if (run != 16'hFFFF) begin
            run <= run + 16'h0001;
        end
        drv <= bus_drive ? drv + 16'h0001 : 16'h0000;
    end
end
// ****************
// properties
// ****************
default clocking cb @(posedge mclk); endclocking
default disable iff (rst);
sequence sym_seen;
    ##[1:4] (rx_symbol_stb && rx_symbol == exp_q);
endsequence
a_passive_class: assert property (chg && !last && pred != `SYM_NONE |-> sym_seen)
    else $error("passive interval misclassified");
a_active_class: assert property (chg && last && pred != `SYM_NONE |-> sym_seen)
    else $error("active interval misclassified");
a_lost_release: assert property (arb_lost |=> !bus_drive [*3])
    else $error("bus still driven after loss");
a_write_start: assert property (data_port_write && bus_idle && !tx_busy && !bus_receive_input
    |-> ##[1:6] bus_drive)
    else $error("idle bus transmit did not start");
a_drive_len: assert property ($fell(bus_drive) |-> drv_ok)
    else $error("driven symbol length wrong");
a_idle_drop: assert property ($rose(bus_receive_input) |-> ##[0:3] !bus_idle)
    else $error("bus idle kept during activity");
a_idle_hold: assert property (!bus_receive_input && !tx_busy && run > `P_IFS_US * C + M
    |-> bus_idle)
    else $error("long passive bus not idle");
a_sym_pulse: assert property (rx_symbol_stb |=> !rx_symbol_stb)
    else $error("symbol strobe longer than one cycle");
a_taken_pulse: assert property (tx_byte_taken |=> !tx_byte_taken)
    else $error("byte taken strobe longer than one cycle");
endmodule
bind vpw_link_controller vpw_link_checker #(.SOF_CNT(SOF_CNT), .SHORT_CNT(SHORT_CNT),
    .LONG_CNT(LONG_CNT)) u_chk (.mclk(mclk), .rst(rst), .bus_receive_input(bus_receive_input),
    .data_port_write(data_port_write), .bus_drive(bus_drive), .rx_symbol(rx_symbol),
    .rx_symbol_stb(rx_symbol_stb), .arb_lost(arb_lost), .tx_busy(tx_busy),
    .tx_byte_taken(tx_byte_taken), .bus_idle(bus_idle));

// *** vpw_link_regs.vh ***
// vpw link controller constants: timing in microseconds, scaled to interface clock periods by CLK_MHZ
// assumes a 125 MHz mclk; each count is time_us * 125 cycles
`ifndef VPW_LINK_REGS_VH
`define VPW_LINK_REGS_VH

`define CLK_MHZ 125
// nominal symbol times in microseconds
`define T_SHORT_US 64
`define T_LONG_US 128
`define T_SOF_US 200
`define T_EOF_US 280
`define T_IFS_US 300
`define T_BRK_US 240
// receive tolerance band edges in microseconds
`define P_A_US 34
`define P_B_US 96
`define P_C_US 163
`define P_D_US 239
`define P_EOF_US 280
`define P_IFS_US 300
`define A_A_US 34
`define A_B_US 96
`define A_C_US 163
`define A_D_US 239
`define A_E_US 240
// late-join window for a transmit write, in clock periods
`define JOIN_WIN 104
// counter width
`define CNT_W 16
`define CNT_MAX 16'hFFFF
// symbol codes from the classifier
`define SYM_NONE 4'h0
`define SYM_BIT0 4'h1
`define SYM_BIT1 4'h2
`define SYM_SOF 4'h3
`define SYM_EOD 4'h4
`define SYM_EOF 4'h5
`define SYM_IFS 4'h6
`define SYM_IDLE 4'h7
`define SYM_BRK 4'h8
`define SYM_INV 4'h9

`endif

// *** vpw_shift_byte.v ***
// byte shift register, msb first, parallel load and parallel read
// assumes load and shift are never asserted together by the caller
`timescale 1ns/100ps
module vpw_shift_byte #(
    parameter W = 8
) (
    input wire mclk,
    input wire rst,
    input wire load,
    input wire [W-1:0] load_data,
    input wire shift,
    input wire shift_in,
    output reg [W-1:0] data,
    output wire msb
);
    assign msb = data[W-1];

    // ******************************************
    // shift path
    // ******************************************
    always @(posedge mclk or posedge rst) begin
        if (rst)
            data <= {W{1'b0}};
        else if (load)
            data <= load_data;
        else if (shift)
            data <= {data[W-2:0], shift_in};
    end
endmodule

// *** vpw_symbol_classifier.v ***
// vpw pulse width classifier: times bus levels and reports symbols
// assumes rx is already synchronous to mclk, high = active
`timescale 1ns/100ps
`include "vpw_link_regs.vh"
module vpw_symbol_classifier #(
    parameter P_A = `P_A_US * `CLK_MHZ,
    parameter P_B = `P_B_US * `CLK_MHZ,
    parameter P_C = `P_C_US * `CLK_MHZ,
    parameter P_D = `P_D_US * `CLK_MHZ,
    parameter P_EOF = `P_EOF_US * `CLK_MHZ,
    parameter P_IFS = `P_IFS_US * `CLK_MHZ,
    parameter A_A = `A_A_US * `CLK_MHZ,
    parameter A_B = `A_B_US * `CLK_MHZ,
    parameter A_C = `A_C_US * `CLK_MHZ,
    parameter A_D = `A_D_US * `CLK_MHZ,
    parameter A_E = `A_E_US * `CLK_MHZ
) (
    input wire mclk,
    input wire rst,
    input wire rx,
    output reg [3:0] sym,
    output reg sym_stb,
    output reg rise_stb,
    output reg [`CNT_W-1:0] count,
    output reg level
);
    reg [`CNT_W-1:0] next_count;
    reg eof_seen;
    reg ifs_seen;
    reg idle_seen;
    reg brk_seen;
    wire edge_now;
    assign edge_now = (rx != level);

    // ******************************************
    // width count and classification
    // ******************************************
    always @* begin
        next_count = count;
        if (count != `CNT_MAX)
            next_count = count + 16'h0001;
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            count <= 16'h0000;
            level <= 1'b0;
            sym <= `SYM_NONE;
            sym_stb <= 1'b0;
            rise_stb <= 1'b0;
            eof_seen <= 1'b0;
            ifs_seen <= 1'b0;
            idle_seen <= 1'b1;
            brk_seen <= 1'b0;
        end else begin
            sym_stb <= 1'b0;
            rise_stb <= 1'b0;
            if (edge_now) begin
                count <= 16'h0001;
                level <= rx;
                rise_stb <= rx;
                eof_seen <= 1'b0;
                ifs_seen <= 1'b0;
                idle_seen <= 1'b0;
                brk_seen <= 1'b0;
                sym_stb <= 1'b1;
                if (rx) begin
                    // passive interval ended
                    if (count < P_A[`CNT_W-1:0])
                        sym <= `SYM_INV;
                    else if (count < P_B[`CNT_W-1:0])
                        sym <= `SYM_BIT0;
                    else if (count < P_C[`CNT_W-1:0])
                        sym <= `SYM_BIT1;
                    else if (count < P_D[`CNT_W-1:0])
                        sym <= `SYM_EOD;
                    else if (count < P_IFS[`CNT_W-1:0])
                        sym <= `SYM_EOF;
                    else
                        sym <= `SYM_IFS;
                end else begin
                    // active interval ended
                    if (count < A_A[`CNT_W-1:0])
                        sym <= `SYM_INV;
                    else if (count < A_B[`CNT_W-1:0])
                        sym <= `SYM_BIT1;
                    else if (count < A_C[`CNT_W-1:0])
                        sym <= `SYM_BIT0;
                    else if (count < A_D[`CNT_W-1:0])
                        sym <= `SYM_SOF;
                    else if (brk_seen)
                        sym <= `SYM_NONE;
                    else
                        sym <= `SYM_INV;
                    if (brk_seen)
                        sym_stb <= 1'b0;
                end
            end else begin
                count <= next_count;
                if (!level && !eof_seen && count == P_EOF[`CNT_W-1:0]) begin
                    eof_seen <= 1'b1;
                    sym <= `SYM_EOF;
                    sym_stb <= 1'b1;
                end
                if (!level && !ifs_seen && count == P_IFS[`CNT_W-1:0]) begin
                    ifs_seen <= 1'b1;
                    idle_seen <= 1'b1;
                    sym <= `SYM_IDLE;
                    sym_stb <= 1'b1;
                end
                if (level && !brk_seen && count == A_E[`CNT_W-1:0]) begin
                    brk_seen <= 1'b1;
                    sym <= `SYM_BRK;
                    sym_stb <= 1'b1;
                end
            end
        end
    end
endmodule
